// ### verilog/usb_proto_pkg.sv
package usb_proto_pkg;

    localparam int ADDR_W      = 7;
    localparam int ENDP_W      = 4;
    localparam int FRAME_W     = 11;
    localparam int TOKEN_BITS  = ADDR_W + ENDP_W;
    localparam int PID_BITS    = 8;
    localparam int SYNC_LEN_FS = 8;
    localparam int SYNC_LEN_HS = 32;
    localparam int ENDP_COUNT  = 16;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

    // packet type codes, msb first as tabulated
    localparam logic [3:0] PID_RSVD  = 4'h0;
    localparam logic [3:0] PID_OUT   = 4'h1;
    localparam logic [3:0] PID_IN    = 4'h9;
    localparam logic [3:0] PID_SOF   = 4'h5;
    localparam logic [3:0] PID_SETUP = 4'hd;
    localparam logic [3:0] PID_DATA0 = 4'h3;
    localparam logic [3:0] PID_DATA1 = 4'hb;
    localparam logic [3:0] PID_DATA2 = 4'h7;
    localparam logic [3:0] PID_MDATA = 4'hf;
    localparam logic [3:0] PID_ACK   = 4'h2;
    localparam logic [3:0] PID_NAK   = 4'ha;
    localparam logic [3:0] PID_STALL = 4'he;
    localparam logic [3:0] PID_NYET  = 4'h6;
    localparam logic [3:0] PID_PRE   = 4'hc;
    localparam logic [3:0] PID_ERR   = 4'hc;
    localparam logic [3:0] PID_SPLIT = 4'h8;
    localparam logic [3:0] PID_PING  = 4'h4;

    // group is selected by the first two bits on the wire, type bits 1:0
    localparam logic [1:0] GRP_SPECIAL   = 2'h0;
    localparam logic [1:0] GRP_TOKEN     = 2'h1;
    localparam logic [1:0] GRP_HANDSHAKE = 2'h2;
    localparam logic [1:0] GRP_DATA      = 2'h3;

    typedef struct packed {
        logic       checkOk;
        logic       defined;
        logic [1:0] group;
        logic [3:0] code;
    } pidInfo_t;

    typedef struct packed {
        logic [3:0]        code;
        logic [ADDR_W-1:0] addr;
        logic [ENDP_W-1:0] endp;
    } tokenInfo_t;

    typedef struct packed {
        logic [3:0] pidType;
        logic       hasData;
    } txReq_t;

endpackage : usb_proto_pkg

// ### verilog/pid_decoder.sv
`timescale 1ns/1ns
module pid_decoder (
    input  wire logic [7:0]              pidByte,
    output usb_proto_pkg::pidInfo_t      info
);
    import usb_proto_pkg::*;

    always_comb begin
        info.code    = pidByte[3:0];
        info.checkOk = (pidByte[7:4] == ~pidByte[3:0]);
        info.defined = (pidByte[3:0] != PID_RSVD);
        info.group   = pidByte[1:0];
    end

endmodule : pid_decoder

// ### verilog/usb_pid_sync_addr_decoder.sv
`timescale 1ns/1ns
module usb_pid_sync_addr_decoder #(
    parameter int NUM_ENDP = usb_proto_pkg::ENDP_COUNT
) (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 hsMode,
    input  wire logic                                 rxActive,
    input  wire logic                                 rxBitValid,
    input  wire logic                                 rxBit,
    input  wire logic                                 expectHandshake,
    input  wire logic                                 addrLoad,
    input  wire logic [usb_proto_pkg::ADDR_W-1:0]     addrValue,
    input  wire logic [NUM_ENDP-1:0]                  epInit,
    input  wire logic [NUM_ENDP-1:0]                  epOutEn,
    input  wire logic [NUM_ENDP-1:0]                  epInEn,
    input  wire logic                                 txStart,
    input  wire usb_proto_pkg::txReq_t                txReq,
    input  wire logic                                 txBitEnable,
    input  wire logic                                 txDataValid,
    input  wire logic [7:0]                           txData,
    output logic [usb_proto_pkg::ADDR_W-1:0]          funcAddr,
    output logic                                      pidEvent,
    output usb_proto_pkg::pidInfo_t                   pidSeen,
    output logic                                      pidError,
    output logic                                      tokenValid,
    output usb_proto_pkg::tokenInfo_t                 token,
    output logic                                      tokenIgnored,
    output logic                                      sofValid,
    output logic [usb_proto_pkg::FRAME_W-1:0]         frameNum,
    output logic                                      rxByteValid,
    output logic [7:0]                                rxByte,
    output logic                                      preSeen,
    output logic                                      errSeen,
    output logic                                      txReady,
    output logic                                      txBit,
    output logic                                      txBitValid,
    output logic                                      txDataTake,
    output logic                                      txDone
);
    import usb_proto_pkg::*;

    typedef enum logic [2:0] {RX_HUNT, RX_PID, RX_TOKEN, RX_DATA, RX_SKIP} rxState_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_PID, TX_DATA} txState_t;

    rxState_t               rxState_reg;
    logic                   prevZero_reg;
    logic [2:0]             pidCnt_reg;
    logic [7:0]             pidShift_reg;
    logic [3:0]             tokCnt_reg;
    logic [TOKEN_BITS-1:0]  fieldShift_reg;
    logic [3:0]             tokCode_reg;
    logic [2:0]             byteCnt_reg;
    logic [7:0]             byteShift_reg;
    logic [ADDR_W-1:0]      funcAddr_reg;
    logic [7:0]             pidByte_next;
    logic [TOKEN_BITS-1:0]  field_next;
    logic [7:0]             byte_next;
    pidInfo_t               pidInfo;
    logic                   pidGood;
    logic                   tokDone;
    logic [ADDR_W-1:0]      tokAddr;
    logic [ENDP_W-1:0]      tokEndp;
    logic                   dirOk;
    logic                   tokHit;

    ////////////////////////////////////////////////////////////////////////
    // receive bit assembly
    assign pidByte_next = {rxBit, pidShift_reg[7:1]};
    assign field_next   = {rxBit, fieldShift_reg[TOKEN_BITS-1:1]};
    assign byte_next    = {rxBit, byteShift_reg[7:1]};
    assign tokAddr      = field_next[ADDR_W-1:0];
    assign tokEndp      = field_next[TOKEN_BITS-1:ADDR_W];
    assign tokDone      = (rxState_reg == RX_TOKEN) && rxBitValid && (tokCnt_reg == 4'(TOKEN_BITS - 1));

    pid_decoder pidDec (
        .pidByte (pidByte_next),
        .info    (pidInfo)
    );

    assign pidGood = pidInfo.checkOk && pidInfo.defined;

    always_comb begin
        unique case (tokCode_reg)
            PID_OUT, PID_SETUP: dirOk = epOutEn[tokEndp];
            PID_IN, PID_PING:   dirOk = epInEn[tokEndp];
            default:            dirOk = 1'b0;
        endcase
    end

    // full compare, no aliasing, endpoint must be initialised
    assign tokHit = (tokAddr == funcAddr_reg) && epInit[tokEndp] && dirOk;

    ////////////////////////////////////////////////////////////////////////
    // receive state machine
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxState_reg <= RX_HUNT;
        end else if (!rxActive) begin
            rxState_reg <= RX_HUNT;
        end else if (rxBitValid) begin
            unique case (rxState_reg)
                RX_HUNT: begin
                    // any run of zeros closed by a one ends sync
                    if (rxBit && prevZero_reg) begin
                        rxState_reg <= RX_PID;
                    end
                end
                RX_PID: begin
                    if (pidCnt_reg == 3'h7) begin
                        if (!pidGood) begin
                            rxState_reg <= RX_SKIP;
                        end else begin
                            unique case (pidInfo.group)
                                GRP_TOKEN: begin
                                    rxState_reg <= RX_TOKEN;
                                end
                                GRP_DATA: begin
                                    rxState_reg <= RX_DATA;
                                end
                                GRP_HANDSHAKE: begin
                                    rxState_reg <= RX_SKIP;
                                end
                                GRP_SPECIAL: begin
                                    if (pidInfo.code == PID_PING) begin
                                        rxState_reg <= RX_TOKEN;
                                    end else begin
                                        rxState_reg <= RX_SKIP;
                                    end
                                end
                            endcase
                        end
                    end
                end
                RX_TOKEN: begin
                    if (tokDone) begin
                        rxState_reg <= RX_SKIP;
                    end
                end
                RX_DATA: begin
                    rxState_reg <= RX_DATA;
                end
                RX_SKIP: begin
                    rxState_reg <= RX_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevZero_reg <= 1'b0;
        end else if (!rxActive || rxState_reg != RX_HUNT) begin
            prevZero_reg <= 1'b0;
        end else if (rxBitValid) begin
            prevZero_reg <= !rxBit;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pidCnt_reg   <= 3'h0;
            pidShift_reg <= 8'h00;
        end else if (rxState_reg != RX_PID) begin
            pidCnt_reg   <= 3'h0;
        end else if (rxBitValid) begin
            pidCnt_reg   <= pidCnt_reg + 3'h1;
            pidShift_reg <= pidByte_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tokCnt_reg     <= 4'h0;
            fieldShift_reg <= '0;
            tokCode_reg    <= PID_RSVD;
        end else if (rxState_reg == RX_PID && rxBitValid) begin
            tokCnt_reg     <= 4'h0;
            tokCode_reg    <= pidByte_next[3:0];
        end else if (rxState_reg == RX_TOKEN && rxBitValid) begin
            tokCnt_reg     <= tokCnt_reg + 4'h1;
            fieldShift_reg <= field_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            byteCnt_reg   <= 3'h0;
            byteShift_reg <= 8'h00;
        end else if (rxState_reg != RX_DATA) begin
            byteCnt_reg   <= 3'h0;
        end else if (rxBitValid) begin
            byteCnt_reg   <= byteCnt_reg + 3'h1;
            byteShift_reg <= byte_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // function address
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            funcAddr_reg <= ADDR_RESET;
        end else if (addrLoad) begin
            funcAddr_reg <= addrValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive event outputs, one-cycle pulses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pidEvent <= 1'b0;
            pidSeen  <= '0;
            pidError <= 1'b0;
            preSeen  <= 1'b0;
            errSeen  <= 1'b0;
        end else begin
            pidEvent <= 1'b0;
            pidError <= 1'b0;
            preSeen  <= 1'b0;
            errSeen  <= 1'b0;
            if (rxActive && rxState_reg == RX_PID && rxBitValid && pidCnt_reg == 3'h7) begin
                pidSeen <= pidInfo;
                pidError <= !pidGood;
                pidEvent <= pidGood;
                if (pidGood && pidInfo.code == PID_PRE) begin
                    // shared code: a reply slot means error handshake
                    errSeen <= expectHandshake;
                    preSeen <= !expectHandshake;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tokenValid   <= 1'b0;
            tokenIgnored <= 1'b0;
            token        <= '0;
            sofValid     <= 1'b0;
            frameNum     <= '0;
        end else begin
            tokenValid   <= 1'b0;
            tokenIgnored <= 1'b0;
            sofValid     <= 1'b0;
            if (rxActive && tokDone) begin
                if (tokCode_reg == PID_SOF) begin
                    sofValid <= 1'b1;
                    frameNum <= field_next;
                end else begin
                    tokenValid   <= tokHit;
                    tokenIgnored <= !tokHit;
                    token        <= '{code: tokCode_reg, addr: tokAddr, endp: tokEndp};
                end
            end
        end
    end

    // bytes are forwarded in wire order, the first being the low-order one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxByteValid <= 1'b0;
            rxByte      <= 8'h00;
        end else begin
            rxByteValid <= 1'b0;
            if (rxActive && rxState_reg == RX_DATA && rxBitValid && byteCnt_reg == 3'h7) begin
                rxByteValid <= 1'b1;
                rxByte      <= byte_next;
            end
        end
    end

    assign funcAddr = funcAddr_reg;

    ////////////////////////////////////////////////////////////////////////
    // transmitter: sync, pid, then optional data bytes
    txState_t   txState_reg;
    logic [4:0] txCnt_reg;
    logic [7:0] txShift_reg;
    logic       txHasData_reg;
    logic [4:0] syncLast;

    assign syncLast = hsMode ? 5'(SYNC_LEN_HS - 1) : 5'(SYNC_LEN_FS - 1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txState_reg   <= TX_IDLE;
            txCnt_reg     <= 5'h00;
            txShift_reg   <= 8'h00;
            txHasData_reg <= 1'b0;
            txBit         <= 1'b0;
            txBitValid    <= 1'b0;
            txDataTake    <= 1'b0;
            txDone        <= 1'b0;
            txReady       <= 1'b1;
        end else begin
            txBitValid <= 1'b0;
            txDataTake <= 1'b0;
            txDone     <= 1'b0;
            unique case (txState_reg)
                TX_IDLE: begin
                    if (txStart) begin
                        txState_reg   <= TX_SYNC;
                        txCnt_reg     <= 5'h00;
                        txShift_reg   <= {~txReq.pidType, txReq.pidType};
                        txHasData_reg <= txReq.hasData;
                        txReady       <= 1'b0;
                    end
                end
                TX_SYNC: begin
                    if (txBitEnable) begin
                        // zeros then a closing one: a transition per zero, the closing one holds the level after nrzi
                        txBit      <= (txCnt_reg == syncLast);
                        txBitValid <= 1'b1;
                        txCnt_reg  <= txCnt_reg + 5'h01;
                        if (txCnt_reg == syncLast) begin
                            txState_reg <= TX_PID;
                            txCnt_reg   <= 5'h00;
                        end
                    end
                end
                TX_PID, TX_DATA: begin
                    if (txBitEnable) begin
                        txBit       <= txShift_reg[0];
                        txBitValid  <= 1'b1;
                        txShift_reg <= {1'b0, txShift_reg[7:1]};
                        txCnt_reg   <= txCnt_reg + 5'h01;
                        if (txCnt_reg == 5'h07) begin
                            txCnt_reg <= 5'h00;
                            if (txHasData_reg && txDataValid) begin
                                txState_reg <= TX_DATA;
                                txShift_reg <= txData;
                                txDataTake  <= 1'b1;
                            end else begin
                                txState_reg <= TX_IDLE;
                                txDone      <= 1'b1;
                                txReady     <= 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence syncMarker;
        rxBitValid && !rxBit && rxActive && rxState_reg == RX_HUNT
        ##1 !rxBitValid && rxActive ##1 rxBitValid && rxBit && rxActive;
    endsequence

    chk_sync_end_lock: assert property (@(posedge clk) disable iff (!reset_n)
        syncMarker |=> rxState_reg == RX_PID)
        else $error("sync marker did not start pid capture");

    chk_pid_entry: assert property (@(posedge clk) disable iff (!reset_n)
        (rxState_reg == RX_PID && $past(rxState_reg) == RX_HUNT) |-> $past(rxBit) && $past(rxBitValid))
        else $error("pid capture entered without marker bit");

    chk_pid_reject: assert property (@(posedge clk) disable iff (!reset_n)
        pidError |-> rxState_reg == RX_SKIP || rxState_reg == RX_HUNT)
        else $error("packet with bad pid not discarded");

    chk_pid_check: assert property (@(posedge clk) disable iff (!reset_n)
        pidEvent |-> pidSeen.checkOk && pidSeen.defined && $past(pidShift_reg[7:5]) == ~pidSeen.code[2:0])
        else $error("pid accepted with failed check");

    chk_token_addr: assert property (@(posedge clk) disable iff (!reset_n)
        tokenValid |-> token.addr == funcAddr_reg && epInit[token.endp])
        else $error("token accepted for other address or endpoint");

    chk_token_dir: assert property (@(posedge clk) disable iff (!reset_n)
        tokenValid && (token.code == PID_OUT || token.code == PID_SETUP) |-> epOutEn[token.endp])
        else $error("out token accepted by endpoint without out");

    chk_addr_hold: assert property (@(posedge clk) disable iff (!reset_n)
        funcAddr_reg != $past(funcAddr_reg) |-> $past(addrLoad))
        else $error("function address changed without load");

    sequence syncDone;
        txState_reg == TX_SYNC && txBitEnable && txCnt_reg == syncLast;
    endsequence

    chk_sync_length: assert property (@(posedge clk) disable iff (!reset_n)
        syncDone |=> txBit && txBitValid && txState_reg == TX_PID)
        else $error("sync not closed by marker at its length");

    chk_tx_lsb_first: assert property (@(posedge clk) disable iff (!reset_n)
        (txState_reg == TX_PID && txBitEnable) |=> txBit == $past(txShift_reg[0]))
        else $error("pid bit not sent lsb first");

endmodule : usb_pid_sync_addr_decoder

// ### tb/usb_host_model.sv
`timescale 1ns/1ns
module usb_host_model (
    input  wire logic clk,
    output logic      rxActive,
    output logic      rxBitValid,
    output logic      rxBit
);
    initial begin
        rxActive   = 1'b0;
        rxBitValid = 1'b0;
        rxBit      = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // a released line shows the inverse of the last bit, never a stale value
    task automatic sendBit(input logic b);
        rxBit      = b;
        rxBitValid = 1'b1;
        @(negedge clk);
        rxBitValid = 1'b0;
        rxBit      = ~b;
        @(negedge clk);
    endtask : sendBit
    // sync shortened on purpose: zeros then the closing marker one
    task automatic sendPkt(input int nSync, input logic [7:0] pidByte, input logic [15:0] fld, input int nFld);
        @(negedge clk);
        rxActive = 1'b1;
        for (int i = 0; i < nSync - 1; i++) sendBit(1'b0);
        sendBit(1'b1);
        for (int i = 0; i < 8; i++) sendBit(pidByte[i]);
        for (int i = 0; i < nFld; i++) sendBit(fld[i]);
        repeat (4) @(negedge clk);
        rxActive = 1'b0;
        repeat (2) @(negedge clk);
    endtask : sendPkt
endmodule : usb_host_model

// ### tb/test_usb_pid_sync_addr_decoder.sv
`timescale 1ns/1ns
module test_usb_pid_sync_addr_decoder;
    import usb_proto_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, hsMode = 1'b0, expectHandshake = 1'b0, addrLoad = 1'b0;
    logic rxActive, rxBitValid, rxBit, txStart = 1'b0, txBitEnable = 1'b0, clr = 1'b1, txDataValid = 1'b0;
    logic [ADDR_W-1:0] addrValue = 7'h00, funcAddr, ma, a;
    logic [15:0] epInit = 16'hffff, epOutEn = 16'hffff, epInEn = 16'hffff, lf = 16'h0010, tw;
    txReq_t txReq = '0;
    pidInfo_t pidSeen;
    tokenInfo_t token;
    logic [FRAME_W-1:0] frameNum;
    logic [7:0] rxByte, pb, txData = 8'h00, byteQ [$];
    logic [8:0] ev;
    logic [3:0] tc, e;
    logic pidEvent, pidError, tokenValid, tokenIgnored, sofValid, rxByteValid, preSeen, errSeen;
    logic txReady, txBit, txBitValid, txDataTake, txDone, m, eb;
    int n_errors = 0, n_checks = 0, cyc = 0, n;
    localparam logic [3:0] TCODE [4] = '{PID_OUT, PID_IN, PID_SETUP, PID_PING};
    always #10 clk = ~clk;
    usb_host_model i_host (.clk(clk), .rxActive(rxActive), .rxBitValid(rxBitValid), .rxBit(rxBit));
    usb_pid_sync_addr_decoder #(.NUM_ENDP(16)) i_dut (.clk(clk), .reset_n(reset_n), .hsMode(hsMode),
        .rxActive(rxActive), .rxBitValid(rxBitValid), .rxBit(rxBit), .expectHandshake(expectHandshake),
        .addrLoad(addrLoad), .addrValue(addrValue), .epInit(epInit), .epOutEn(epOutEn), .epInEn(epInEn),
        .txStart(txStart), .txReq(txReq), .txBitEnable(txBitEnable), .txDataValid(txDataValid), .txData(txData),
        .funcAddr(funcAddr), .pidEvent(pidEvent), .pidSeen(pidSeen), .pidError(pidError),
        .tokenValid(tokenValid), .token(token), .tokenIgnored(tokenIgnored), .sofValid(sofValid),
        .frameNum(frameNum), .rxByteValid(rxByteValid), .rxByte(rxByte), .preSeen(preSeen),
        .errSeen(errSeen), .txReady(txReady), .txBit(txBit), .txBitValid(txBitValid),
        .txDataTake(txDataTake), .txDone(txDone));
    ////////////////////////////////////////////////////////////////////////////
    // sticky record of nine pulses, all but txBitValid and txDataTake, since the last clear
    always @(posedge clk) begin
        ev <= clr ? 9'h000 : ev | {rxByteValid, txDone, errSeen, preSeen, sofValid, tokenIgnored, tokenValid,
            pidError, pidEvent};
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // rx byte model: every rxByteValid pops the next byte sent on the wire
    always @(negedge clk) begin
        if (rxByteValid) begin
            chk("rxByteQ", {8'h00, byteQ.size() > 0 ? byteQ.pop_front() : 8'hxx}, {8'h00, rxByte});
        end
    end
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        n_checks++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic pkt(input int ns, input logic [7:0] pidByte, input logic [15:0] f, input int nf);
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        i_host.sendPkt(ns, pidByte, f, nf);
    endtask : pkt
    task automatic summarize();
        if (n_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        chk("funcAddr", 16'h0000, {9'h0, funcAddr});
        ma = ADDR_RESET;
        for (int c = 0; c < 16; c++) begin
            expectHandshake = c[0];
            pkt(2 + c % 7, {~c[3:0], c[3:0]}, 16'h0000, 0);
            chk("events", c == 0 ? 9'h002 : c == 12 ? (c[0] ? 9'h041 : 9'h021) : 9'h001, ev);
            if (c != 0) chk("pidSeen", {10'h0, c[1:0], c[3:0]}, {10'h0, pidSeen.group, pidSeen.code});
        end
        pkt(8, 8'h99, 16'h0000, 0);
        chk("badCheck", 9'h002, ev);
        expectHandshake = 1'b1;
        pkt(8, {~PID_ERR, PID_ERR}, 16'h0000, 0);
        chk("errEvents", 9'h041, ev);
        expectHandshake = 1'b0;
        for (int k = 0; k < 12; k++) begin
            lf = lfsr(lf);
            if (k == 4) begin
                addrValue = lf[6:0];
                addrLoad  = 1'b1;
                @(negedge clk);
                addrLoad = 1'b0;
                ma = lf[6:0];
                @(negedge clk);
                chk("funcAddr", {9'h0, ma}, {9'h0, funcAddr});
            end
            epInit  = ~(16'h0001 << lf[15:12]);
            epOutEn = lf | 16'h5555;
            epInEn  = lf | 16'haaaa;
            tc = TCODE[lf[9:8]];
            a  = lf[10] ? ma : ma ^ (7'h01 << lf[13:11]);
            e  = lf[3:0];
            m  = (a == ma) && epInit[e] && ((tc == PID_IN || tc == PID_PING) ? epInEn[e] : epOutEn[e]);
            pkt(3, {~tc, tc}, {5'h00, e, a}, 11);
            chk("tokenEvents", m ? 9'h005 : 9'h009, ev);
            chk("token", {1'b0, tc, a, e}, {1'b0, token});
        end
        lf = lfsr(lf);
        pkt(5, {~PID_SOF, PID_SOF}, lf, 11);
        chk("sofEvents", 9'h011, ev);
        chk("frameNum", {5'h00, lf[10:0]}, {5'h00, frameNum});
        byteQ = '{lf[7:0], lf[15:8]};
        pkt(4, {~PID_DATA0, PID_DATA0}, lf, 16);
        chk("dataEvents", 9'h101, ev);
        chk("byteQ", 16'h0000, 16'(byteQ.size()));
        chk("rxByte", {8'h00, lf[15:8]}, {8'h00, rxByte});
        for (int h = 0; h < 2; h++) begin
            lf = lfsr(lf);
            hsMode = (h == 1);
            txReq.pidType = lf[3:0];
            txReq.hasData = (h == 1);
            txData = lf[15:8];
            txDataValid = (h == 1);
            pb = {~lf[3:0], lf[3:0]};
            tw = {lf[15:8], pb};
            n = h == 1 ? SYNC_LEN_HS : SYNC_LEN_FS;
            clr = 1'b1;
            txStart = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            txStart = 1'b0;
            for (int i = 0; i < n + 8 + 8 * h; i++) begin
                txBitEnable = 1'b1;
                @(negedge clk);
                txBitEnable = 1'b0;
                eb = i < n - 1 ? 1'b0 : i == n - 1 ? 1'b1 : tw[(i - n) & 15];
                chk("txBit", {14'h0, 1'b1, eb}, {14'h0, txBitValid, txBit});
                chk("txCtl", {14'h0, i == n + 7 && h == 1, i == n + 7 + 8 * h}, {14'h0, txDataTake, txReady});
                if (txDataTake) txDataValid = 1'b0;
                @(negedge clk);
            end
            repeat (3) @(negedge clk);
            chk("txDone", 16'h0003, {14'h0, txReady, ev[7]});
        end
        summarize();
    end
endmodule : test_usb_pid_sync_addr_decoder
